// >>> apc_pkg.sv
// Shared constants, frame layout and record type for the parameter command frame parser
package apc_pkg;
	localparam logic [7:0] START_MARK = 8'h7E;
	localparam logic [7:0] CHK_GOOD = 8'hFF;
	localparam logic [7:0] TYPE_LOCAL = 8'h08;
	localparam logic [7:0] TYPE_QUEUE = 8'h09;
	localparam logic [7:0] TYPE_REMOTE = 8'h07;
	localparam logic [7:0] ID_SILENT = 8'h00;
	// Command names, two ASCII characters
	localparam logic [15:0] NAME_APPLY = 16'h4143;
	localparam logic [15:0] NAME_NODE = 16'h4E49;
	localparam logic [15:0] NAME_BAUD = 16'h4244;
	localparam logic [15:0] NAME_DEST = 16'h444C;
	// Body positions, counted from offset 3
	localparam logic [15:0] P_TYPE = 16'h0000;
	localparam logic [15:0] P_ID = 16'h0001;
	localparam logic [15:0] P_NAME_HI = 16'h0002;
	localparam logic [15:0] P_NAME_LO = 16'h0003;
	localparam logic [15:0] P_PARAM = 16'h0004;
	localparam logic [15:0] R_OPT = 16'h000A;
	localparam logic [15:0] R_NAME_HI = 16'h000B;
	localparam logic [15:0] R_NAME_LO = 16'h000C;
	localparam logic [15:0] R_PARAM = 16'h000D;
	localparam int OPT_APPLY_BIT = 1;
	// Setting slots and their values after reset
	localparam int NUM_SET = 3;
	localparam logic [1:0] SET_NODE = 2'h0;
	localparam logic [1:0] SET_BAUD = 2'h1;
	localparam logic [1:0] SET_DEST = 2'h2;
	localparam logic [31:0] NODE_RESET = 32'h00000000;
	localparam logic [31:0] BAUD_RESET = 32'h00000003;
	localparam logic [31:0] DEST_RESET = 32'h00000000;

	typedef struct packed {
		logic remote;
		logic [7:0] id;
		logic [15:0] name;
		logic has_value;
		logic apply;
		logic unknown;
		logic [31:0] value;
	} apc_rec_s;
endpackage

// >>> apc_rec_if.sv
// Record channel between the parser and its two-entry output buffer
`timescale 1ns/1ps
`default_nettype none
interface apc_rec_if;
	import apc_pkg::*;
	logic in_valid;
	logic in_ready;
	apc_rec_s in_rec;
	logic out_valid;
	logic out_ready;
	apc_rec_s out_rec;
	modport parser (output in_valid, output in_rec, input in_ready,
		input out_valid, input out_rec, output out_ready);
	modport buffer (input in_valid, input in_rec, output in_ready,
		output out_valid, output out_rec, input out_ready);
endinterface
`default_nettype wire

// >>> apc_buf2.sv
// Two-entry record buffer; record output straight from entry 0, valid from its own flop
`timescale 1ns/1ps
`default_nettype none
module apc_buf2 (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	apc_rec_if.buffer ch
);
	import apc_pkg::*;
	apc_rec_s entry0;
	apc_rec_s entry1;
	logic [1:0] count;
	logic [1:0] next_count;
	logic has_head;
	wire push = ch.in_valid && ch.in_ready;
	wire pop = ch.out_valid && ch.out_ready;

	// Entry 0 is the head; ready falls only when both are held
	assign ch.in_ready = (count != 2'h2);
	// Head valid has its own flop so the port never sees a decode
	assign ch.out_valid = has_head;
	assign ch.out_rec = entry0;
	assign next_count = count + {1'b0, push} - {1'b0, pop};

	// Shift on pop, fill the lowest free slot on push
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			count <= 2'h0;
			has_head <= 1'b0;
			entry0 <= '0;
			entry1 <= '0;
		end else begin
			if (pop) begin
				entry0 <= (push && count == 2'h1) ? ch.in_rec : entry1;
			end else if (push && count == 2'h0) begin
				entry0 <= ch.in_rec;
			end
			if (push && ((count == 2'h1 && !pop) || count == 2'h2)) begin
				entry1 <= ch.in_rec;
			end
			count <= next_count;
			has_head <= (next_count != 2'h0);
		end
	end
endmodule
`default_nettype wire

// >>> apc_frame_parser.sv
// Parameter command frame parser with local setting store
`timescale 1ns/1ps
`default_nettype none
module apc_frame_parser (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_ready,
	input wire logic i_rec_ready,
	output logic o_rec_valid,
	output logic o_rec_remote,
	output logic [7:0] o_rec_id,
	output logic [15:0] o_rec_name,
	output logic o_rec_has_value,
	output logic o_rec_apply,
	output logic o_rec_unknown,
	output logic [31:0] o_rec_value,
	output logic [31:0] o_node_label_param,
	output logic [31:0] o_baud_rate_param,
	output logic [31:0] o_destination_low_param
);
	import apc_pkg::*;

	typedef enum logic [2:0] {ST_START, ST_LEN_HI, ST_LEN_LO, ST_BODY, ST_CHK, ST_EMIT} apc_state_e;

	apc_state_e state;
	apc_state_e next_state;
	logic rdy;
	logic [7:0] len_hi;
	logic [15:0] len;
	logic [15:0] pos;
	logic [7:0] sum;
	logic [7:0] ftype;
	logic [7:0] fid;
	logic [15:0] name;
	logic [7:0] opts;
	logic [31:0] val;
	logic has_val;
	apc_rec_s rec;
	apc_rec_s next_rec;
	logic [NUM_SET-1:0][31:0] act;
	logic [NUM_SET-1:0][31:0] pend;
	logic [NUM_SET-1:0][31:0] next_pend;
	logic [1:0] sel;
	logic known;

	apc_rec_if ch ();

	apc_buf2 u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.ch(ch)
	);

	// Byte handshake and frame-level decode
	wire accept = i_rx_valid && rdy;
	wire [7:0] sum_next = sum + i_rx_data;
	wire is_remote = (ftype == TYPE_REMOTE);
	wire local_type = (ftype == TYPE_LOCAL) || (ftype == TYPE_QUEUE);
	wire [15:0] name_hi_pos = is_remote ? R_NAME_HI : P_NAME_HI;
	wire [15:0] name_lo_pos = is_remote ? R_NAME_LO : P_NAME_LO;
	wire [15:0] param_pos = is_remote ? R_PARAM : P_PARAM;
	wire [15:0] pos_next = pos + 16'h0001;
	wire body_acc = (state == ST_BODY) && accept;
	wire chk_acc = (state == ST_CHK) && accept;
	wire sum_ok = (sum_next == CHK_GOOD);
	wire good = chk_acc && sum_ok;
	wire is_apply = (name == NAME_APPLY);
	wire wr = good && local_type && has_val && known;
	wire commit = good && ((ftype == TYPE_LOCAL) || (local_type && is_apply));
	wire want_rsp = local_type && (fid != ID_SILENT);
	wire want = want_rsp || is_remote;

	// Setting slot from command name
	always_comb begin
		known = 1'b1;
		unique case (name)
			NAME_NODE: sel = SET_NODE;
			NAME_BAUD: sel = SET_BAUD;
			NAME_DEST: sel = SET_DEST;
			default: begin
				sel = SET_NODE;
				known = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_pend = pend;
		if (wr) begin
			next_pend[sel] = val;
		end
	end

	// Record for the host or the remote path
	always_comb begin
		next_rec = '0;
		next_rec.remote = is_remote;
		next_rec.id = fid;
		next_rec.name = name;
		next_rec.has_value = has_val;
		next_rec.apply = is_remote ? opts[OPT_APPLY_BIT] : commit;
		next_rec.unknown = local_type && !known && !is_apply;
		next_rec.value = (has_val || is_remote) ? val : act[sel];
	end

	// Frame sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			ST_START: begin
				if (accept && i_rx_data == START_MARK) begin
					next_state = ST_LEN_HI;
				end
			end
			ST_LEN_HI: begin
				if (accept) begin
					next_state = ST_LEN_LO;
				end
			end
			ST_LEN_LO: begin
				if (accept) begin
					next_state = ({len_hi, i_rx_data} == 16'h0000) ? ST_CHK : ST_BODY;
				end
			end
			ST_BODY: begin
				if (accept && pos_next == len) begin
					next_state = ST_CHK;
				end
			end
			ST_CHK: begin
				if (accept) begin
					next_state = (sum_ok && want) ? ST_EMIT : ST_START;
				end
			end
			ST_EMIT: begin
				if (ch.in_ready) begin
					next_state = ST_START;
				end
			end
		endcase
	end

	assign ch.in_valid = (state == ST_EMIT);
	assign ch.in_rec = rec;
	assign ch.out_ready = i_rec_ready;

	// Port view of ready, the buffer head and the active settings; all registered
	assign o_rx_ready = rdy;
	assign o_rec_valid = ch.out_valid;
	assign o_rec_remote = ch.out_rec.remote;
	assign o_rec_id = ch.out_rec.id;
	assign o_rec_name = ch.out_rec.name;
	assign o_rec_has_value = ch.out_rec.has_value;
	assign o_rec_apply = ch.out_rec.apply;
	assign o_rec_unknown = ch.out_rec.unknown;
	assign o_rec_value = ch.out_rec.value;
	assign o_node_label_param = act[SET_NODE];
	assign o_baud_rate_param = act[SET_BAUD];
	assign o_destination_low_param = act[SET_DEST];

	// State, handshake and length; ready stays low while a record waits
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= ST_START;
			rdy <= 1'b0;
			len_hi <= 8'h00;
			len <= 16'h0000;
		end else begin
			state <= next_state;
			rdy <= (next_state != ST_EMIT);
			if (state == ST_LEN_HI && accept) begin
				len_hi <= i_rx_data;
			end
			if (state == ST_LEN_LO && accept) begin
				len <= {len_hi, i_rx_data};
			end
		end
	end

	// Body field capture, cleared at each marker
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || (state == ST_START && accept)) begin
			pos <= 16'h0000;
			sum <= 8'h00;
			ftype <= 8'h00;
			fid <= 8'h00;
			name <= 16'h0000;
			opts <= 8'h00;
			val <= 32'h00000000;
			has_val <= 1'b0;
		end else if (body_acc) begin
			pos <= pos_next;
			sum <= sum_next;
			if (pos == P_TYPE) begin
				ftype <= i_rx_data;
			end
			if (pos == P_ID) begin
				fid <= i_rx_data;
			end
			if (pos == name_hi_pos) begin
				name[15:8] <= i_rx_data;
			end
			if (pos == name_lo_pos) begin
				name[7:0] <= i_rx_data;
			end
			if (is_remote && pos == R_OPT) begin
				opts <= i_rx_data;
			end
			if (pos >= param_pos) begin
				val <= {val[23:0], i_rx_data};
				has_val <= 1'b1;
			end
		end
	end

	// Setting store and pending record; only good frames touch it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			act <= {DEST_RESET, BAUD_RESET, NODE_RESET};
			pend <= {DEST_RESET, BAUD_RESET, NODE_RESET};
			rec <= '0;
		end else if (good) begin
			pend <= next_pend;
			rec <= next_rec;
			if (commit) begin
				act <= next_pend;
			end
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	hunt_marker_a: assert property (state == ST_START && accept && i_rx_data != START_MARK |=> state == ST_START)
		else $error("non-marker byte left the hunt state");
	len_order_a: assert property (state == ST_LEN_LO && accept |=> len == {$past(len_hi), $past(i_rx_data)})
		else $error("length not assembled high byte first");
	bad_sum_a: assert property (chk_acc && !sum_ok |=> state == ST_START ##1 !ch.in_valid)
		else $error("frame with bad checksum was acted on");
	good_emit_a: assert property (good && want |=> state == ST_EMIT && rec.id == $past(fid))
		else $error("good frame did not queue its record");
	apply_now_a: assert property (good && ftype == TYPE_LOCAL |=> act == pend)
		else $error("local command did not apply pending settings");
	queue_hold_a: assert property (good && ftype == TYPE_QUEUE && !is_apply |=> act == $past(act))
		else $error("queued write changed an active setting");
	read_now_a: assert property (good && local_type && !has_val && known |=> rec.value == $past(act[sel]))
		else $error("read did not return the current value");
	silent_id_a: assert property (ch.in_valid && !rec.remote |-> rec.id != ID_SILENT)
		else $error("response queued for a zero identifier");
	pad_value_a: assert property (body_acc && pos >= param_pos |=> val == {$past(val[23:0]), $past(i_rx_data)})
		else $error("parameter bytes not shifted in order");
	name_hi_a: assert property (body_acc && pos == P_NAME_HI && !is_remote |=> name[15:8] == $past(i_rx_data))
		else $error("first name character misplaced");
	remote_opt_a: assert property (ch.in_valid && rec.remote |-> rec.apply == opts[OPT_APPLY_BIT])
		else $error("remote apply flag does not follow the option bit");
	value_write_a: assert property (wr |=> pend[$past(sel)] == $past(val))
		else $error("written value not stored as pending");
	echo_id_a: assert property (ch.in_valid && ch.in_ready |-> rec.id == fid)
		else $error("record identifier differs from the request");
endmodule
`default_nettype wire

// >>> apc_host_model.sv
// Host byte source model feeding the parameter frame parser
`timescale 1ns/1ps
`default_nettype none
module apc_host_model (
	input wire logic i_clk_sys,
	input wire logic i_ready,
	input wire logic [3:0] i_gap,
	output logic o_valid,
	output logic [7:0] o_data
);
	logic [7:0] q[$];
	logic took;
	int idle;
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
		took = 1'b0;
		idle = 0;
	end
	task put(input logic [7:0] b);
		q.push_back(b);
	endtask
	// Handshake seen at the sampling edge only
	always @(posedge i_clk_sys) begin
		took <= o_valid && i_ready;
	end
	// bytes in order
	// Hold until taken; a released line shows inverted data, never stale
	always @(negedge i_clk_sys) begin
		if (took && o_valid) begin
			idle = i_gap;
			if (idle == 0 && q.size() > 0)
				o_data = q.pop_front();
			else begin
				o_valid = 1'b0;
				o_data = ~o_data;
			end
		end else if (!o_valid && idle > 0)
			idle--;
		else if (!o_valid && q.size() > 0) begin
			o_data = q.pop_front();
			o_valid = 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tb_api_param_command_frames.sv
// Self-checking bench for the parameter command frame parser
`timescale 1ns/1ps
`default_nettype none
module tb_api_param_command_frames;
	import apc_pkg::*;
	typedef struct {
		logic [7:0] ty;
		logic [7:0] id;
		logic [15:0] nm;
		int np;
		logic [31:0] pv;
		logic [7:0] opt;
		logic [3:0] fl;
		logic [31:0] val;
		logic [31:0] exp_node;
		logic [31:0] exp_baud;
		logic [31:0] exp_dest;
	} apc_row_s;
	// Flags: record, value checked, apply, unknown
	apc_row_s rows[11] = '{
		'{8'h08, 8'h01, NAME_BAUD, 1, 32'h8, 8'h0, 4'hE, 32'h8, 32'h0, 32'h8, 32'h0},
		'{8'h09, 8'h02, NAME_BAUD, 2, 32'h7, 8'h0, 4'hC, 32'h7, 32'h0, 32'h8, 32'h0},
		'{8'h09, 8'h03, NAME_BAUD, 0, 32'h0, 8'h0, 4'hC, 32'h8, 32'h0, 32'h8, 32'h0},
		'{8'h09, 8'h04, NAME_APPLY, 0, 32'h0, 8'h0, 4'hA, 32'h0, 32'h0, 32'h7, 32'h0},
		'{8'h09, 8'h00, NAME_NODE, 4, 32'h12, 8'h0, 4'h0, 32'h0, 32'h0, 32'h7, 32'h0},
		'{8'h08, 8'h05, NAME_DEST, 0, 32'h0, 8'h0, 4'hE, 32'h0, 32'h12, 32'h7, 32'h0},
		'{8'h08, 8'h06, NAME_NODE, 0, 32'h0, 8'h0, 4'hE, 32'h12, 32'h12, 32'h7, 32'h0},
		'{8'h07, 8'h00, 16'h4431, 1, 32'h3, 8'h02, 4'hE, 32'h3, 32'h12, 32'h7, 32'h0},
		'{8'h07, 8'h07, NAME_DEST, 2, 32'h1234, 8'h00, 4'hC, 32'h1234, 32'h12, 32'h7, 32'h0},
		'{8'h08, 8'h08, 16'h5A5A, 0, 32'h0, 8'h0, 4'hF, 32'h12, 32'h12, 32'h7, 32'h0},
		'{8'h08, 8'h09, NAME_DEST, 4, 32'hC0A80064, 8'h0, 4'hE, 32'hC0A80064, 32'h12, 32'h7, 32'hC0A80064}};
	logic clk, rst, rx_valid, rx_ready, rec_ready, rec_valid;
	logic [7:0] rx_data;
	logic [3:0] gap;
	logic [31:0] node, baud, dest;
	apc_rec_s got, r;
	apc_rec_s rq[$];
	int error_cnt = 0;
	int checks = 0;

	apc_host_model u_host (.i_clk_sys(clk), .i_ready(rx_ready), .i_gap(gap), .o_valid(rx_valid), .o_data(rx_data));
	apc_frame_parser u_dut (.i_clk_sys(clk), .i_rst(rst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
		.o_rx_ready(rx_ready), .i_rec_ready(rec_ready), .o_rec_valid(rec_valid), .o_rec_remote(got.remote),
		.o_rec_id(got.id), .o_rec_name(got.name), .o_rec_has_value(got.has_value), .o_rec_apply(got.apply),
		.o_rec_unknown(got.unknown), .o_rec_value(got.value), .o_node_label_param(node),
		.o_baud_rate_param(baud), .o_destination_low_param(dest));

	// Free-running clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Collect each record on the edge that pops it
	always @(posedge clk) begin
		if (rec_valid && rec_ready)
			rq.push_back(got);
	end

	task check(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task summarize;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// frame built from the layout, checksum computed here
	task automatic send(input apc_row_s w, input logic bad);
		logic [7:0] b[$];
		logic [7:0] s;
		b = '{w.ty, w.id};
		if (w.ty == TYPE_REMOTE)
			b = {b, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8, 8'h00, 8'h64, w.opt};
		b = {b, w.nm[15:8], w.nm[7:0]};
		for (int i = w.np - 1; i >= 0; i--)
			b.push_back(w.pv[8*i +: 8]);
		s = 8'hFF;
		foreach (b[i])
			s -= b[i];
		u_host.put(START_MARK);
		u_host.put(8'h00);
		u_host.put(8'(b.size()));
		foreach (b[i])
			u_host.put(b[i]);
		u_host.put(s ^ {7'h00, bad});
	endtask
	// Bounded wait for the host to go quiet, then let the record land
	task automatic settle;
		int n;
		n = 0;
		while ((u_host.q.size() != 0 || rx_valid) && n < 400) begin
			@(negedge clk);
			n++;
		end
		repeat (8) @(negedge clk);
	endtask
	task check_set(input logic [31:0] n, input logic [31:0] b, input logic [31:0] d);
		check(node, n, "node");
		check(baud, b, "baud");
		check(dest, d, "dest");
	endtask

	// Watchdog, far above the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		rec_ready = 1'b1;
		gap = 4'h0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check_set(NODE_RESET, BAUD_RESET, DEST_RESET); // settings after reset
		foreach (rows[k]) begin
			send(rows[k], 1'b0);
			settle();
			check(32'(rq.size()), 32'(rows[k].fl[3]), "records"); // silent id
			if (rq.size() != 0) begin
				r = rq.pop_front();
				check(32'(r.id), 32'(rows[k].id), "id"); // id echo
				check(32'(r.name), 32'(rows[k].nm), "name"); // name order
				check(32'(r.remote), 32'(rows[k].ty == TYPE_REMOTE), "remote"); // forwarded frame
				check(32'(r.has_value), 32'(rows[k].np != 0), "has value"); // write or read
				check(32'(r.apply), 32'(rows[k].fl[1]), "apply"); // apply flag
				check(32'(r.unknown), 32'(rows[k].fl[0]), "unknown"); // unknown name
				if (rows[k].fl[2])
					check(r.value, rows[k].val, "value"); // value
			end
			check_set(rows[k].exp_node, rows[k].exp_baud, rows[k].exp_dest); // active settings
		end
		// Garbage, then a corrupted write, then a good read
		u_host.put(8'h55);
		u_host.put(8'hAA);
		send(rows[0], 1'b1);
		send(rows[2], 1'b0);
		settle();
		check(32'(rq.size()), 32'h1, "after bad frame"); // frame dropped
		r = rq.pop_front();
		check(32'(r.id), 32'h3, "resync id"); // hunt resumes
		check(baud, 32'h7, "baud kept"); // no effect
		// Consumer stalls with a slow host: buffer fills, nothing lost
		rec_ready = 1'b0;
		gap = 4'h2;
		send(rows[2], 1'b0);
		send(rows[6], 1'b0);
		send(rows[9], 1'b0);
		repeat (150) @(negedge clk);
		check(32'(rx_ready), 32'h0, "stalled"); // backpressure
		check(32'(rec_valid), 32'h1, "head held"); // record waits
		rec_ready = 1'b1;
		gap = 4'h0;
		settle();
		check(32'(rq.size()), 32'h3, "drained"); // no loss
		foreach (rows[k]) begin
			if (k == 2 || k == 6 || k == 9) begin
				r = rq.pop_front();
				check(32'(r.id), 32'(rows[k].id), "order"); // frame order
			end
		end
		// Reset in mid-frame restores settings
		send(rows[0], 1'b0);
		repeat (4) @(negedge clk);
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		settle();
		check(32'(rq.size()), 32'h0, "no record"); // tail ignored
		check_set(NODE_RESET, BAUD_RESET, DEST_RESET); // reset values
		summarize();
	end
endmodule
`default_nettype wire
